// ===== hdl/snu_shift_unit.sv
// Shift and normalize functional unit with six-rank shifter and exponent adder
//
// Contract
// - Normalize takes 400 ns, all other shifts 300 ns; shifts here take 8 clocks of 40 ns, 320 ns.
// - Normalize builds its count first, then shifts the coefficient.
// - Shifter is 60 bits, six ranks of 1..32 places, either direction.
// - Each shift count bit enables one rank; maximum shift is 63.
// - Count comes from immediate field, index low bits, or normalize network.
// - Immediate field is presented every cycle; used only by immediate shifts.
// - Go starts the unit; busy holds until release, then results go out.
// - Operand read yields to higher user; result transmit takes first place.
// - Nominal right shift with index bits 6-10 nonzero gives zero word.
// - Op 20 rotates destination word left by the immediate count.
// - Op 21 shifts destination right end-off with sign fill.
// - Op 22 rotates left, or right arithmetic if index negative.
// - Op 23 right arithmetic, or rotates left if index negative.
// - Negative index: complement the low six bits, reverse direction.
// - Normalize complements negatives, counts leading zeros from bit 47, restores sign.
// - Normalize writes word and count; underflow clears exponent and coefficient.
// - Exponent adder subtracts count via complemented exponent plus count.
// - Zero coefficient lowers the exponent by 48.
// - Infinite or indefinite exponent: word passes unchanged, count is zero.
`timescale 1ns/10ps
`default_nettype none
module snu_shift_unit (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic go,
    input wire logic [5:0] opcode,
    input wire logic release_unit,
    input wire logic [5:0] immediate_count_field,
    input wire logic [snu_pkg::WORD_W-1:0] operand_word,
    input wire logic [snu_pkg::INDEX_W-1:0] operand_index,
    input wire logic read_trunk_taken,
    output logic busy,
    output logic read_req,
    output logic complete,
    output logic result_valid,
    output logic result_word_we,
    output logic result_index_we,
    output logic [snu_pkg::WORD_W-1:0] result_word,
    output logic [snu_pkg::INDEX_W-1:0] result_index
);
    import snu_pkg::*;

    snu_state_type state, next_state;
    logic [5:0] op_reg, next_op_reg;
    logic [WORD_W-1:0] shift_input_reg, next_shift_input_reg;
    logic [WORD_W-1:0] pass_word, next_pass_word;
    logic [INDEX_W-1:0] index_operand_reg, next_index_operand_reg;
    logic [COUNT_W-1:0] imm_reg, next_imm_reg;
    logic [COUNT_W-1:0] shift_count_reg, next_shift_count_reg;
    logic [EXP_W-1:0] norm_exp, next_norm_exp;
    logic [3:0] cyc, next_cyc;
    logic dir_left, next_dir_left;
    logic zero_out, next_zero_out;
    logic norm_sign, next_norm_sign;
    logic norm_special, next_norm_special;
    logic next_busy, next_read_req, next_complete, next_result_valid;
    logic next_result_word_we, next_result_index_we;
    logic [WORD_W-1:0] next_result_word;
    logic [INDEX_W-1:0] next_result_index;

    logic take;
    logic is_norm;
    logic [3:0] op_limit;
    logic [COUNT_W-1:0] norm_count;
    logic [WORD_W-1:0] shift_out;
    logic [WORD_W-1:0] rank [0:6];

    assign take = (state == SNU_READ) && !read_trunk_taken;
    assign is_norm = (op_reg == OP_NORMALIZE);
    assign op_limit = is_norm ? NORM_OP_CYC : SHIFT_OP_CYC;

    // Six ranks; rank i moves 2**i places when its count bit is set
    assign rank[0] = shift_input_reg;
    generate
        for (genvar i = 0; i < 6; i++) begin : g_rank
            localparam int S = 2 ** i;
            assign rank[i+1] = !shift_count_reg[i] ? rank[i] :
                dir_left ? {rank[i][WORD_W-1-S:0], rank[i][WORD_W-1:WORD_W-S]} :
                {{S{shift_input_reg[SIGN_BIT]}}, rank[i][WORD_W-1:S]};
        end
    endgenerate
    assign shift_out = rank[6];

    // Leading zeros from bit 47; the highest set bit wins
    always_comb begin
        norm_count = ZERO_COEF_COUNT;
        for (int i = 0; i < COEF_W; i++) begin
            if (shift_input_reg[i]) begin
                norm_count = 6'(COEF_W - 1 - i);
            end
        end
    end

    always_comb begin
        logic neg;
        logic [WORD_W-1:0] work;
        logic [WORD_W-1:0] pos;
        logic [EXP_W:0] exp_sum;
        neg = 1'b0;
        work = WORD_RESET;
        pos = WORD_RESET;
        exp_sum = '0;
        next_state = state;
        next_op_reg = op_reg;
        next_shift_input_reg = shift_input_reg;
        next_pass_word = pass_word;
        next_index_operand_reg = index_operand_reg;
        next_imm_reg = imm_reg;
        next_shift_count_reg = shift_count_reg;
        next_norm_exp = norm_exp;
        next_cyc = cyc;
        next_dir_left = dir_left;
        next_zero_out = zero_out;
        next_norm_sign = norm_sign;
        next_norm_special = norm_special;
        next_busy = busy;
        next_read_req = read_req;
        next_complete = complete;
        next_result_valid = 1'b0;
        next_result_word_we = 1'b0;
        next_result_index_we = 1'b0;
        next_result_word = result_word;
        next_result_index = result_index;
        unique case (state)
            SNU_IDLE: begin
                if (go) begin
                    next_op_reg = opcode;
                    next_busy = 1'b1;
                    next_read_req = 1'b1;
                    next_state = SNU_READ;
                end
            end
            SNU_READ: begin
                if (take) begin
                    next_read_req = 1'b0;
                    next_index_operand_reg = operand_index;
                    next_imm_reg = immediate_count_field;
                    next_pass_word = operand_word;
                    next_cyc = CYC_RESET;
                    if (is_norm) begin
                        neg = operand_word[SIGN_BIT];
                        work = neg ? ~operand_word : operand_word;
                        next_norm_sign = neg;
                        next_norm_exp = work[WORD_W-2:EXP_LSB];
                        next_norm_special = (work[WORD_W-2:EXP_LSB] == EXP_INFINITE) ||
                            (work[WORD_W-2:EXP_LSB] == EXP_INDEFINITE);
                        next_shift_input_reg = {12'h0, work[COEF_W-1:0]};
                    end else begin
                        next_shift_input_reg = operand_word;
                    end
                    next_state = SNU_COUNT;
                end
            end
            SNU_COUNT: begin
                next_cyc = cyc + 4'h1;
                next_zero_out = 1'b0;
                if (is_norm) begin
                    // The count transfer is blocked for infinite and indefinite
                    next_shift_count_reg = norm_special ? COUNT_RESET : norm_count;
                    next_dir_left = 1'b1;
                end else if (op_reg == OP_NOMINAL_LEFT || op_reg == OP_NOMINAL_RIGHT) begin
                    neg = index_operand_reg[INDEX_SIGN_BIT];
                    next_shift_count_reg = neg ? ~index_operand_reg[COUNT_W-1:0] :
                        index_operand_reg[COUNT_W-1:0];
                    next_dir_left = (op_reg == OP_NOMINAL_LEFT) ^ neg;
                    // A count with any of bits 6-10 set empties an end-off shift
                    next_zero_out = !((op_reg == OP_NOMINAL_LEFT) ^ neg) && (neg ?
                        |(~index_operand_reg[ONES_HI:ONES_LO]) :
                        |index_operand_reg[ONES_HI:ONES_LO]);
                end else begin
                    next_shift_count_reg = imm_reg;
                    next_dir_left = (op_reg == OP_ROTATE_LEFT_IMM);
                end
                next_state = SNU_EXECUTE;
            end
            SNU_EXECUTE: begin
                next_cyc = cyc + 4'h1;
                if (cyc == op_limit - 4'h1) begin
                    if (is_norm) begin
                        exp_sum = {1'b0, ~norm_exp} + {6'h0, shift_count_reg};
                        pos = exp_sum[EXP_W] ? WORD_RESET :
                            {1'b0, ~exp_sum[EXP_W-1:0], shift_out[COEF_W-1:0]};
                        next_result_word = norm_special ? pass_word :
                            (norm_sign ? ~pos : pos);
                        next_result_index = {12'h0, shift_count_reg};
                    end else begin
                        next_result_word = zero_out ? WORD_RESET : shift_out;
                    end
                    next_complete = 1'b1;
                    next_state = SNU_HOLD;
                end
            end
            SNU_HOLD: begin
                if (release_unit) begin
                    next_busy = 1'b0;
                    next_complete = 1'b0;
                    next_result_valid = 1'b1;
                    next_result_word_we = 1'b1;
                    next_result_index_we = is_norm;
                    next_state = SNU_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state <= SNU_IDLE;
            op_reg <= OP_RESET;
            shift_input_reg <= WORD_RESET;
            pass_word <= WORD_RESET;
            index_operand_reg <= INDEX_RESET;
            imm_reg <= COUNT_RESET;
            shift_count_reg <= COUNT_RESET;
            norm_exp <= EXP_RESET;
            cyc <= CYC_RESET;
            dir_left <= 1'b0;
            zero_out <= 1'b0;
            norm_sign <= 1'b0;
            norm_special <= 1'b0;
            busy <= 1'b0;
            read_req <= 1'b0;
            complete <= 1'b0;
            result_valid <= 1'b0;
            result_word_we <= 1'b0;
            result_index_we <= 1'b0;
            result_word <= WORD_RESET;
            result_index <= INDEX_RESET;
        end else begin
            state <= next_state;
            op_reg <= next_op_reg;
            shift_input_reg <= next_shift_input_reg;
            pass_word <= next_pass_word;
            index_operand_reg <= next_index_operand_reg;
            imm_reg <= next_imm_reg;
            shift_count_reg <= next_shift_count_reg;
            norm_exp <= next_norm_exp;
            cyc <= next_cyc;
            dir_left <= next_dir_left;
            zero_out <= next_zero_out;
            norm_sign <= next_norm_sign;
            norm_special <= next_norm_special;
            busy <= next_busy;
            read_req <= next_read_req;
            complete <= next_complete;
            result_valid <= next_result_valid;
            result_word_we <= next_result_word_we;
            result_index_we <= next_result_index_we;
            result_word <= next_result_word;
            result_index <= next_result_index;
        end
    end

    // Cycles since operand capture, read only by the checks below
    logic [3:0] since_take;
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            since_take <= CYC_RESET;
        end else begin
            since_take <= take ? CYC_RESET : since_take + 4'h1;
        end
    end

    // The ranks rotate modulo the word width, so counts of 60 to 63 wrap around
    logic [5:0] rot_amt;
    assign rot_amt = (shift_count_reg >= 6'h3c) ? shift_count_reg - 6'h3c : shift_count_reg;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    a_op_time: assert property ($rose(complete) |-> since_take == op_limit)
        else $error("operation time wrong");
    a_norm_count_first: assert property ((state == SNU_COUNT && is_norm && !norm_special)
        |=> shift_count_reg == $past(norm_count) && state == SNU_EXECUTE)
        else $error("normalize count not loaded before shift");
    a_rotate_left: assert property ((state == SNU_EXECUTE && dir_left)
        |-> shift_out == 60'({shift_input_reg, shift_input_reg} >>
        (7'h3c - {1'b0, rot_amt})))
        else $error("left rotate wrong");
    a_right_arith: assert property ((state == SNU_EXECUTE && !dir_left)
        |-> shift_out == 60'($signed(shift_input_reg) >>> shift_count_reg))
        else $error("right end-off shift wrong");
    a_imm_select: assert property ((state == SNU_COUNT && (op_reg == OP_ROTATE_LEFT_IMM ||
        op_reg == OP_ARITH_RIGHT_IMM)) |=> shift_count_reg == $past(imm_reg))
        else $error("immediate count not selected");
    a_release_busy: assert property ((state == SNU_HOLD && release_unit)
        |=> !busy && result_valid ##1 !result_valid)
        else $error("release did not end the operation");
    a_read_yield: assert property ((state == SNU_READ && read_trunk_taken)
        |=> state == SNU_READ && read_req)
        else $error("operand read did not yield");
    a_ones_zero: assert property ((state == SNU_EXECUTE && zero_out && !is_norm &&
        cyc == op_limit - 4'h1) |=> result_word == WORD_RESET)
        else $error("ones test did not clear the word");
    a_special_pass: assert property ((state == SNU_EXECUTE && is_norm && norm_special &&
        cyc == op_limit - 4'h1) |=> result_index == INDEX_RESET
        && result_word == $past(pass_word))
        else $error("special operand altered");
    a_nominal_neg: assert property ((state == SNU_COUNT && op_reg == OP_NOMINAL_LEFT &&
        index_operand_reg[INDEX_SIGN_BIT]) |=> !dir_left
        && shift_count_reg == ~$past(index_operand_reg[5:0]))
        else $error("negative index not reversed");
endmodule
`default_nettype wire

// ===== hdl/snu_pkg.sv
// Constants and types for the shift and normalize unit
package snu_pkg;
    localparam int CLOCK_NS = 40;
    localparam int SHIFT_OP_NS = 300;
    localparam int NORM_OP_NS = 400;
    localparam logic [3:0] SHIFT_OP_CYC = 4'((SHIFT_OP_NS + CLOCK_NS - 1) / CLOCK_NS);
    localparam logic [3:0] NORM_OP_CYC = 4'((NORM_OP_NS + CLOCK_NS - 1) / CLOCK_NS);
    localparam logic [5:0] OP_ROTATE_LEFT_IMM = 6'h10;
    localparam logic [5:0] OP_ARITH_RIGHT_IMM = 6'h11;
    localparam logic [5:0] OP_NOMINAL_LEFT = 6'h12;
    localparam logic [5:0] OP_NOMINAL_RIGHT = 6'h13;
    localparam logic [5:0] OP_NORMALIZE = 6'h14;
    localparam int WORD_W = 60;
    localparam int INDEX_W = 18;
    localparam int COEF_W = 48;
    localparam int EXP_W = 11;
    localparam int COUNT_W = 6;
    localparam int SIGN_BIT = 59;
    localparam int EXP_LSB = 48;
    localparam int INDEX_SIGN_BIT = 17;
    localparam int ONES_LO = 6;
    localparam int ONES_HI = 10;
    localparam logic [10:0] EXP_INFINITE = 11'h3ff;
    localparam logic [10:0] EXP_INDEFINITE = 11'h7ff;
    localparam logic [5:0] ZERO_COEF_COUNT = 6'h30;
    localparam logic [59:0] WORD_RESET = 60'h0;
    localparam logic [17:0] INDEX_RESET = 18'h0;
    localparam logic [5:0] COUNT_RESET = 6'h0;
    localparam logic [5:0] OP_RESET = 6'h0;
    localparam logic [10:0] EXP_RESET = 11'h0;
    localparam logic [3:0] CYC_RESET = 4'h0;
    typedef enum logic [2:0] {
        SNU_IDLE,
        SNU_READ,
        SNU_COUNT,
        SNU_EXECUTE,
        SNU_HOLD
    } snu_state_type;
endpackage

// ===== test/snu_trunk_model.sv
// Operand trunk model: a higher-priority user that can hold the trunk, then operand delivery
`timescale 1ns/10ps
`default_nettype none
module snu_trunk_model (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic read_req,
    input wire logic [3:0] stall_cycles,
    input wire logic [59:0] word_in,
    input wire logic [17:0] index_in,
    output logic read_trunk_taken,
    output logic [59:0] operand_word,
    output logic [17:0] operand_index
);
    logic [3:0] held;
    // Off-grant the trunk toggles so a capture at the wrong edge never sees stale operands
    always @(negedge clock) begin
        if (!rst_b) begin
            held <= 4'h0;
            read_trunk_taken <= 1'b0;
            operand_word <= 60'h0;
            operand_index <= 18'h0;
        end else begin
            if (read_req && held >= stall_cycles) begin
                operand_word <= word_in;
                operand_index <= index_in;
            end else begin
                operand_word <= ~operand_word;
                operand_index <= ~operand_index;
            end
            if (!read_req) begin
                held <= 4'h0;
                read_trunk_taken <= 1'b0;
            end else if (held < stall_cycles) begin
                held <= held + 4'h1;
                read_trunk_taken <= 1'b1;
            end else begin
                read_trunk_taken <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// ===== test/shift_normalize_unit_tb_top.sv
// Self-checking testbench for the shift and normalize unit
`timescale 1ns/10ps
`default_nettype none
module shift_normalize_unit_tb_top;
    import snu_pkg::*;
    logic clock, rst_b, go, release_unit, read_trunk_taken;
    logic [5:0] opcode, immediate_count_field;
    logic [59:0] operand_word, word_in, result_word;
    logic [17:0] operand_index, index_in, result_index;
    logic [3:0] stall_cycles;
    logic busy, read_req, complete, result_valid, result_word_we, result_index_we;
    int failures = 0;
    int num_checks = 0;
    snu_shift_unit snu_shift_unit_i (.clock(clock), .rst_b(rst_b), .go(go), .opcode(opcode),
        .release_unit(release_unit), .immediate_count_field(immediate_count_field),
        .operand_word(operand_word), .operand_index(operand_index),
        .read_trunk_taken(read_trunk_taken), .busy(busy), .read_req(read_req),
        .complete(complete), .result_valid(result_valid), .result_word_we(result_word_we),
        .result_index_we(result_index_we), .result_word(result_word),
        .result_index(result_index));
    snu_trunk_model snu_trunk_model_i (.clock(clock), .rst_b(rst_b), .read_req(read_req),
        .stall_cycles(stall_cycles), .word_in(word_in), .index_in(index_in),
        .read_trunk_taken(read_trunk_taken), .operand_word(operand_word),
        .operand_index(operand_index));
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic check(input logic [63:0] seen, input logic [63:0] expd);
        num_checks++;
        if (seen !== expd) begin
            failures++;
            $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, expd);
        end
    endtask
    function automatic logic [59:0] rotl(input logic [59:0] w, input logic [5:0] c);
        int k;
        k = c % 60;
        return (w << k) | (w >> (60 - k));
    endfunction
    function automatic logic [59:0] sra(input logic [59:0] w, input logic [5:0] c);
        return 60'($signed(w) >>> c);
    endfunction
    function automatic logic [59:0] nom_ref(input logic [5:0] op, input logic [59:0] w,
        input logic [17:0] x);
        logic [5:0] c;
        c = x[17] ? ~x[5:0] : x[5:0];
        if ((op == OP_NOMINAL_LEFT) != x[17]) return rotl(w, c);
        if (|(x[17] ? ~x[10:6] : x[10:6])) return 60'h0;
        return sra(w, c);
    endfunction
    function automatic logic [77:0] norm_ref(input logic [59:0] w);
        logic [59:0] p, r;
        logic [11:0] sum;
        logic [5:0] cnt;
        int i;
        p = w[59] ? ~w : w;
        cnt = 6'h0;
        if (p[58:48] == EXP_INFINITE || p[58:48] == EXP_INDEFINITE) return {18'h0, w};
        for (i = 47; i >= 0 && p[i] == 1'b0; i--) cnt++;
        sum = {1'b0, ~p[58:48]} + {6'h0, cnt};
        r = sum[11] ? 60'h0 : {1'b0, ~sum[10:0], p[47:0] << cnt};
        if (w[59]) r = ~r;
        return {12'h0, cnt, r};
    endfunction
    task automatic run_op(input logic [5:0] op, input logic [59:0] w, input logic [17:0] x,
        input logic [5:0] imm, input logic [3:0] stall, input logic poke,
        input logic [59:0] exp_w, input logic [17:0] exp_x);
        int n;
        logic norm;
        norm = (op == OP_NORMALIZE);
        n = 0;
        word_in = w;
        index_in = x;
        stall_cycles = stall;
        immediate_count_field = imm;
        opcode = op;
        go = 1'b1;
        @(negedge clock);
        go = 1'b0;
        opcode = ~op;
        check(busy, 1);
        while (read_req !== 1'b0) begin
            @(negedge clock);
            n++;
            if (n > 40) begin
                failures++;
                tally_and_finish();
            end
        end
        check(n, stall + 1);
        // Field is inverted once after capture; only the capture-edge value may count
        immediate_count_field = ~imm;
        n = 0;
        while (complete !== 1'b1) begin
            @(negedge clock);
            n++;
            go = poke && n == 2;
            release_unit = poke && n == 2;
            if (n > 40) begin
                failures++;
                tally_and_finish();
            end
        end
        check(n, norm ? NORM_OP_CYC : SHIFT_OP_CYC);
        check({busy, result_valid}, 2'b10);
        release_unit = 1'b1;
        @(negedge clock);
        release_unit = 1'b0;
        check({busy, complete, result_valid, result_word_we}, 4'b0011);
        check(result_index_we, norm);
        check(result_word, exp_w);
        if (norm) check(result_index, exp_x);
        @(negedge clock);
        check({result_valid, result_word_we, result_index_we}, 3'b000);
    endtask
    localparam logic [59:0] W = 60'h812_3456_789a_bcde;
    task automatic t_immediate();
        int c;
        for (c = 0; c < 6; c++) begin
            run_op(OP_ROTATE_LEFT_IMM, W, 18'h0, 6'(1 << c), 4'h0, 1'b0, rotl(W, 6'(1 << c)),
                18'h0);
        end
        run_op(OP_ROTATE_LEFT_IMM, W, 18'h0, 6'h3f, 4'h0, 1'b0, rotl(W, 6'h3f), 18'h0);
        run_op(OP_ARITH_RIGHT_IMM, W, 18'h0, 6'h3f, 4'h1, 1'b0, sra(W, 6'h3f), 18'h0);
        run_op(OP_ARITH_RIGHT_IMM, W >> 1, 18'h007c0, 6'h05, 4'h0, 1'b0, sra(W >> 1, 6'h05),
            18'h0);
        $display("test immediate done");
    endtask
    task automatic t_nominal();
        logic [17:0] xs [4] = '{18'h00007, 18'h3fffa, 18'h00047, 18'h3f83a};
        int i;
        for (i = 0; i < 8; i++) begin
            run_op(i < 4 ? OP_NOMINAL_LEFT : OP_NOMINAL_RIGHT, W, xs[i % 4], 6'h3f, 4'(i % 4),
                1'b0, nom_ref(i < 4 ? OP_NOMINAL_LEFT : OP_NOMINAL_RIGHT, W, xs[i % 4]),
                18'h0);
        end
        $display("test nominal done");
    endtask
    task automatic t_normalize();
        logic [59:0] ws [6] = '{60'h400_0001_2345_6789, ~60'h400_0001_2345_6789,
            60'h400_0000_0000_0000, 60'h3ff_0000_0000_0005, ~60'h7ff_0000_0000_0007,
            60'h001_0001_2345_6789};
        logic [77:0] r;
        int i;
        for (i = 0; i < 6; i++) begin
            r = norm_ref(ws[i]);
            run_op(OP_NORMALIZE, ws[i], 18'h3ffff, 6'h2a, 4'h1, 1'b0, r[59:0],
                r[77:60]);
        end
        $display("test normalize done");
    endtask
    task automatic t_refused();
        run_op(OP_ARITH_RIGHT_IMM, W, 18'h0, 6'h0c, 4'h2, 1'b1, sra(W, 6'h0c), 18'h0);
        $display("test refused done");
    endtask
    initial begin
        rst_b = 1'b0;
        go = 1'b0;
        release_unit = 1'b0;
        opcode = 6'h0;
        immediate_count_field = 6'h0;
        word_in = 60'h0;
        index_in = 18'h0;
        stall_cycles = 4'h0;
        repeat (20) @(negedge clock);
        check({busy, read_req, complete, result_valid}, 4'h0);
        check(result_word, 60'h0);
        check(result_index, 18'h0);
        rst_b = 1'b1;
        @(negedge clock);
        check({busy, read_req, complete, result_word_we, result_index_we}, 5'h0);
        $display("test reset done");
        t_immediate();
        t_nominal();
        t_normalize();
        t_refused();
        tally_and_finish();
    end
endmodule
`default_nettype wire
